/* File: verilog/adc_input_reference_select.sv */
/*
 * APB register block and conversion sequencer for the converter's
 * input, gain, reference and ground selection.
 * Assumes triggers and the window data are synchronous to clk; the
 * analog result arrives on resultIn when resultValid pulses.
 */
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module adc_input_reference_select
    import adc_sel_pkg::*;
#(
    parameter int RPT_WIDTH = 3
)
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        trigPin,
    input  wire logic        trigTimer,
    input  wire logic        trigLogic,
    input  wire logic        resultValid,
    input  wire logic [11:0] resultIn,
    output logic      [19:0] extSelect,
    output logic      [3:0]  intSelect,
    output logic             useAgnd,
    output logic      [1:0]  gainSelect,
    output logic      [1:0]  refSource,
    output logic             fastRefEnable,
    output logic             tenBitMode,
    output logic             trackPhase,
    output logic             convPhase,
    output logic             irq
);
    typedef enum logic [1:0] {IDLE, TRACK, CONV} phase_t;

    typedef struct packed {
        logic [1:0]  gain;
        logic        tenBit;
        logic [2:0]  trig;
        logic [RPT_WIDTH-1:0] rpt;
        logic [4:0]  chan;
        logic [1:0]  refSel;
        logic        gndSel;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [15:0] winLo;
        logic [15:0] winHi;
        logic [15:0] acc;
        logic [15:0] data;
        logic [7:0]  done; // Holds up to 128 results
        logic [7:0]  cnt;
        phase_t      phase;
        logic        pinPrev;
        logic        timerPrev;
        logic        logicPrev;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [19:0] ext;
        logic [3:0]  intl;
        logic        analog_ground_pin;
        logic        fastEn;
        logic        irq;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic [19:0] decExt;
    logic [3:0]  decInt;
    logic        decAgnd;

    // Depth of accumulation beyond 16 full-scale results would overflow the 16-bit sum
    initial begin
        if (RPT_WIDTH < 1 || RPT_WIDTH > 3) begin
            $error("RPT_WIDTH must be 1..3");
        end
    end

    // Number of conversions requested: 2 to the power of the field
    function automatic logic [7:0] rptCount(logic [RPT_WIDTH-1:0] f);
        rptCount = 8'h01 << f;
    endfunction

    // Register address match on the exact byte address
    function automatic logic hit(logic [11:0] a, logic [11:0] off);
        hit = (a == off);
    endfunction

    adc_route_decode u_route (
        .chanCode   (st_ff.chan),
        .refSel     (st_ff.refSel),
        .gndSel     (st_ff.gndSel),
        .tracking   (nxt_st.phase == TRACK),
        .converting (nxt_st.phase == CONV),
        .extSelect  (decExt),
        .intSelect  (decInt),
        .useAgnd    (decAgnd)
    );

    // Whole next state: bus, trigger, sequencer and interrupt
    always_comb begin
        logic access;
        logic wr;
        logic start;
        logic [1:0] setEv;
        logic [15:0] sum;
        access = psel && penable && !st_ff.ready;
        wr = access && pwrite;
        start = 1'b0;
        setEv = 2'b00;
        sum = st_ff.acc + {4'h0, resultIn};
        nxt_st = st_ff;
        nxt_st.ready = access;
        nxt_st.err = 1'b0;
        nxt_st.pinPrev = trigPin;
        nxt_st.timerPrev = trigTimer;
        nxt_st.logicPrev = trigLogic;

        // Trigger selection: edges from hardware sources
        case (st_ff.trig)
            TRIG_SW: start = wr && hit(paddr, OFF_CTRL0)
                && pwdata[CTRL0_BUSY_BIT];
            TRIG_PIN: start = trigPin && !st_ff.pinPrev;
            TRIG_TIMER: start = trigTimer && !st_ff.timerPrev;
            TRIG_LOGIC: start = trigLogic && !st_ff.logicPrev;
            default: start = 1'b0;
        endcase

        // Register writes
        if (wr) begin
            case (paddr)
                OFF_CTRL0: nxt_st.gain = pwdata[CTRL0_GAIN_LSB +: 2];
                OFF_CTRL1: begin
                    nxt_st.tenBit = pwdata[CTRL1_BITS_BIT];
                    nxt_st.trig = pwdata[CTRL1_TRIG_LSB +: 3];
                    nxt_st.rpt = pwdata[CTRL1_RPT_LSB +: RPT_WIDTH];
                end
                OFF_CHAN: nxt_st.chan = pwdata[4:0];
                OFF_REF: begin
                    nxt_st.refSel = pwdata[REF_SEL_LSB +: 2];
                    nxt_st.gndSel = pwdata[REF_GND_BIT];
                end
                OFF_STATUS: nxt_st.status = st_ff.status & ~pwdata[1:0];
                OFF_MASK: nxt_st.mask = pwdata[1:0];
                OFF_WINLO: nxt_st.winLo = pwdata[15:0];
                OFF_WINHI: nxt_st.winHi = pwdata[15:0];
                OFF_DATA, OFF_STATE: ;
                default: nxt_st.err = 1'b1;
            endcase
        end

        // Sequencer: track, convert, repeat until count reached
        case (st_ff.phase)
            IDLE: begin
                if (start) begin
                    nxt_st.phase = TRACK;
                    nxt_st.cnt = 8'(TRACK_CYC);
                    nxt_st.acc = 16'h0000;
                    nxt_st.done = '0;
                end
            end
            TRACK: begin
                if (st_ff.cnt <= 8'h01) begin
                    nxt_st.phase = CONV;
                    nxt_st.cnt = st_ff.tenBit ? 8'(CONV10_CYC)
                                              : 8'(CONV12_CYC);
                end else begin
                    nxt_st.cnt = st_ff.cnt - 8'h01;
                end
            end
            CONV: begin
                if (st_ff.cnt > 8'h01) begin
                    nxt_st.cnt = st_ff.cnt - 8'h01;
                end
                if (resultValid) begin
                    nxt_st.acc = sum;
                    nxt_st.done = st_ff.done + 1'b1;
                    if (st_ff.done + 8'h01
                        >= rptCount(st_ff.rpt)) begin
                        nxt_st.phase = IDLE;
                        nxt_st.data = sum;
                        setEv[ST_DONE] = 1'b1;
                        setEv[ST_WIN] = (sum >= st_ff.winLo)
                            && (sum <= st_ff.winHi);
                    end else begin
                        nxt_st.phase = TRACK;
                        nxt_st.cnt = 8'(TRACK_CYC);
                    end
                end
            end
            default: nxt_st.phase = IDLE;
        endcase

        // New events win over a clear in the same cycle
        nxt_st.status = nxt_st.status | setEv;

        // Read mux
        nxt_st.rdata = 32'h0000_0000;
        if (access && !pwrite) begin
            case (paddr)
                OFF_CTRL0: nxt_st.rdata = {27'h0, st_ff.phase != IDLE,
                                           2'h0, st_ff.gain};
                OFF_CTRL1: nxt_st.rdata = 32'(st_ff.rpt) << CTRL1_RPT_LSB
                    | {28'h0, st_ff.trig, st_ff.tenBit};
                OFF_CHAN: nxt_st.rdata = {27'h0, st_ff.chan};
                OFF_REF: nxt_st.rdata = {29'h0, st_ff.gndSel, st_ff.refSel};
                OFF_STATUS: nxt_st.rdata = {30'h0, st_ff.status};
                OFF_MASK: nxt_st.rdata = {30'h0, st_ff.mask};
                OFF_DATA: nxt_st.rdata = {16'h0, st_ff.data};
                OFF_WINLO: nxt_st.rdata = {16'h0, st_ff.winLo};
                OFF_WINHI: nxt_st.rdata = {16'h0, st_ff.winHi};
                OFF_STATE: nxt_st.rdata = {6'h0, st_ff.fastEn, st_ff.analog_ground_pin,
                                           st_ff.intl, st_ff.ext};
                default: nxt_st.err = 1'b1;
            endcase
        end

        // Routing registered so extSelect, intSelect and useAgnd come from flip-flops
        nxt_st.ext = decExt;
        nxt_st.intl = decInt;
        nxt_st.analog_ground_pin = decAgnd;
        // Fast reference powered only through a conversion cycle
        nxt_st.fastEn = (st_ff.refSel == REF_FAST)
            && (nxt_st.phase != IDLE);
        nxt_st.irq = |(nxt_st.status & nxt_st.mask);
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= '0;
            st_ff.chan <= CH_NONE;
            st_ff.phase <= IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdata;
    assign pready = st_ff.ready;
    assign pslverr = st_ff.err;
    assign extSelect = st_ff.ext;
    assign intSelect = st_ff.intl;
    assign useAgnd = st_ff.analog_ground_pin;
    assign gainSelect = st_ff.gain;
    assign refSource = st_ff.refSel;
    assign fastRefEnable = st_ff.fastEn;
    assign tenBitMode = st_ff.tenBit;
    assign trackPhase = st_ff.phase == TRACK;
    assign convPhase = st_ff.phase == CONV;
    assign irq = st_ff.irq;
endmodule // adc_input_reference_select

/* File: verilog/adc_sel_pkg.sv */
/*
 * Constants for the converter input and reference selection block.
 * Assumes a single 100 MHz clock and an APB master with 32-bit data.
 */
// Summary of operation
// - Five-bit channel code; codes 0 to 19 route external inputs 0 to 19.
// - Codes 20,21,22,23,31 pick temperature, regulator, supply, ground, none.
// - Two-bit gain field picks 1x, 0.75x, 0.5x or 0.25x.
// - Resolution selectable between 12-bit and 10-bit single-ended.
// - Reference field picks fast internal, supply, regulator or pin; ground bit.
// - Fast internal reference enabled only while a conversion needs it.
// - Ground bit set uses analog ground pin during tracking and conversion.
// - Temperature sensor input samples against internal chip ground during tracking.
// - Fast internal reference forces internal ground during conversion.
// - Trigger from software, external pin, timer or logic events.
// - Separate interrupt flags for conversion done and window match.
// - Several successive conversions accumulate into one output value.
// - Writing one to busy bit starts conversion under software trigger.
// - After the requested count accumulates, the done flag is set.
package adc_sel_pkg;
    localparam logic [11:0] OFF_CTRL0  = 12'h000; // gain, busy, start
    localparam logic [11:0] OFF_CTRL1  = 12'h004; // bits, trigger, repeat
    localparam logic [11:0] OFF_CHAN   = 12'h008;
    localparam logic [11:0] OFF_REF    = 12'h00c;
    localparam logic [11:0] OFF_STATUS = 12'h010; // write one to clear
    localparam logic [11:0] OFF_MASK   = 12'h014;
    localparam logic [11:0] OFF_DATA   = 12'h018;
    localparam logic [11:0] OFF_WINLO  = 12'h01c;
    localparam logic [11:0] OFF_WINHI  = 12'h020;
    localparam logic [11:0] OFF_STATE  = 12'h024; // routing readback
    // Control 0 fields
    localparam int CTRL0_GAIN_LSB = 0;
    localparam int CTRL0_BUSY_BIT = 4;
    // Control 1 fields
    localparam int CTRL1_BITS_BIT = 0;
    localparam int CTRL1_TRIG_LSB = 1;
    localparam int CTRL1_RPT_LSB  = 4;
    // Reference fields
    localparam int REF_SEL_LSB = 0;
    localparam int REF_GND_BIT = 2;
    // Status bits
    localparam int ST_DONE = 0;
    localparam int ST_WIN  = 1;
    // Channel codes
    localparam logic [4:0] CH_LAST_EXT = 5'h13;
    localparam logic [4:0] CH_TEMP     = 5'h14;
    localparam logic [4:0] CH_REG      = 5'h15;
    localparam logic [4:0] CH_SUPPLY   = 5'h16;
    localparam logic [4:0] CH_GND      = 5'h17;
    localparam logic [4:0] CH_NONE     = 5'h1f;
    // Reference source codes
    localparam logic [1:0] REF_FAST   = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_REG    = 2'h2;
    localparam logic [1:0] REF_PIN    = 2'h3;
    // Trigger source codes
    localparam logic [2:0] TRIG_SW    = 3'h0;
    localparam logic [2:0] TRIG_PIN   = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_LOGIC = 3'h3;
    // Timing: tracking length in ns, conversion lengths in clock cycles
    localparam int TRACK_NS    = 100;
    localparam int CLK_NS      = 10;
    localparam int TRACK_CYC   = (TRACK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV12_CYC  = 13;
    localparam int CONV10_CYC  = 11;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

/* File: verilog/adc_route_decode.sv */
/*
 * Channel and ground routing decode for the converter front end.
 * Assumes codes are stable registered values; phase flags are next-state decodes.
 */
`timescale 1ns/1ns
module adc_route_decode
    import adc_sel_pkg::*;
(
    input  wire logic [4:0]  chanCode,
    input  wire logic [1:0]  refSel,
    input  wire logic        gndSel,
    input  wire logic        tracking,
    input  wire logic        converting,
    output logic      [19:0] extSelect,
    output logic      [3:0]  intSelect,
    output logic             useAgnd
);
    // One-hot external pins, internal sources as temp/reg/supply/gnd
    always_comb begin
        extSelect = 20'h00000;
        intSelect = 4'h0;
        if (chanCode <= CH_LAST_EXT) begin
            extSelect[chanCode] = 1'b1;
        end else begin
            case (chanCode)
                CH_TEMP:   intSelect = 4'h1;
                CH_REG:    intSelect = 4'h2;
                CH_SUPPLY: intSelect = 4'h4;
                CH_GND:    intSelect = 4'h8;
                default:   intSelect = 4'h0;
            endcase
        end
    end

    // Analog ground only when no override claims the phase
    always_comb begin
        useAgnd = gndSel && (tracking || converting);
        if (chanCode == CH_TEMP && tracking) begin
            useAgnd = 1'b0;
        end
        if (refSel == REF_FAST && converting) begin
            useAgnd = 1'b0;
        end
    end
endmodule // adc_route_decode

/* File: verif/adc_sel_asserts.sv */
/* Port assertions for the input and reference selection block.
   Bound to every instance of the top module; one clock domain. */
`timescale 1ns/1ns
module adc_sel_asserts
    import adc_sel_pkg::*;
#(
    parameter int RPT_WIDTH = 3
)
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [19:0] extSelect,
    input wire logic [3:0]  intSelect,
    input wire logic        useAgnd,
    input wire logic [1:0]  refSource,
    input wire logic        fastRefEnable,
    input wire logic        trackPhase,
    input wire logic        convPhase
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Routing never connects two sources at once
    ext_onehot_a: assert property ($onehot0(extSelect))
        else $error("external route not one-hot");
    int_onehot_a: assert property ($onehot0(intSelect))
        else $error("internal route not one-hot");
    route_excl_a: assert property (!(|extSelect && |intSelect))
        else $error("external and internal routed together");
    // Ground overrides win over the ground bit
    temp_gnd_a: assert property (trackPhase && intSelect[0] |-> !useAgnd)
        else $error("analog ground used while sampling temperature");
    fast_gnd_a: assert property (
        convPhase && refSource == REF_FAST |-> !useAgnd)
        else $error("analog ground used with fast reference");
    fast_en_a: assert property (fastRefEnable |-> refSource == REF_FAST)
        else $error("fast reference enabled while not selected");
    // Tracking lasts exactly ten cycles, never overlapping conversion
    track_len_a: assert property ($rose(trackPhase) |->
        trackPhase [*8] ##1 trackPhase [*2] ##1 !trackPhase)
        else $error("tracking length wrong");
    phase_excl_a: assert property (!(trackPhase && convPhase))
        else $error("tracking and conversion overlap");
    pready_ans_a: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer late");
endmodule // adc_sel_asserts

bind adc_input_reference_select adc_sel_asserts #(
    .RPT_WIDTH(RPT_WIDTH)
) adc_sel_asserts_i (
    .clk, .reset, .psel, .penable, .pready, .extSelect, .intSelect,
    .useAgnd, .refSource, .fastRefEnable, .trackPhase, .convPhase
);

/* File: verif/tb_top.sv */
/* Self-checking bench for the selection block.
   Drives APB, the trigger inputs and a small converter model. */
`timescale 1ns/1ns
module tb_top;
    import adc_sel_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, resultIn;
    logic [31:0] pwdata, prdata;
    logic        trigPin, trigTimer, trigLogic, resultValid;
    logic [19:0] extSelect;
    logic [3:0]  intSelect;
    logic [1:0]  gainSelect, refSource;
    logic        useAgnd, fastRefEnable, tenBitMode;
    logic        trackPhase, convPhase, irq;
    int          errors, checks_done, nRes, cvCnt;
    logic [15:0] sumExp;

    adc_input_reference_select adc_input_reference_select_i (
        .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trigPin, .trigTimer, .trigLogic, .resultValid,
        .resultIn, .extSelect, .intSelect, .useAgnd, .gainSelect,
        .refSource, .fastRefEnable, .tenBitMode, .trackPhase, .convPhase,
        .irq
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Converter model; result lines scramble outside the valid pulse
    always @(posedge clk) begin
        if (convPhase === 1'b1 && resultValid !== 1'b1 && cvCnt == 3) begin
            resultValid <= 1'b1;
            resultIn <= 12'h0a0 + 12'(nRes);
            sumExp = sumExp + 16'h00a0 + 16'(nRes);
            nRes = nRes + 1;
            cvCnt = 0;
        end else begin
            resultValid <= 1'b0;
            resultIn <= ~resultIn;
            if (convPhase === 1'b1) cvCnt = cvCnt + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask

    // Every channel code, reserved ones included
    task automatic t_chan();
        logic [31:0] ex, in;
        for (int c = 0; c < 32; c++) begin
            wr(OFF_CHAN, 32'(c));
            ex = (c < 20) ? (32'h1 << c) : 32'h0;
            in = (c >= 20 && c < 24) ? (32'h1 << (c - 20)) : 32'h0;
            chk({12'h000, extSelect}, ex);
            chk({28'h0, intSelect}, in);
            rd(OFF_STATE, {8'h00, in[3:0], ex[19:0]});
        end
    endtask

    // Gain, reference, resolution, then an unmapped offset
    task automatic t_cfg();
        logic [31:0] r;
        logic        e;
        for (int v = 0; v < 4; v++) begin
            wr(OFF_CTRL0, 32'(v));
            chk({30'h0, gainSelect}, 32'(v));
            wr(OFF_REF, 32'(v));
            chk({30'h0, refSource}, 32'(v));
            rd(OFF_REF, 32'(v));
            wr(OFF_CTRL1, 32'(v & 1));
            chkb(tenBitMode, 1'(v & 1));
        end
        apb(1'b0, 12'h030, 32'h0, r, e);
        chk(r, 32'h0);
        chkb(e, 1'b1);
    endtask

    // One conversion cycle; ground and reference checked mid-phase
    task automatic t_conv(input logic [2:0] tg, input logic [2:0] rpt,
                          input logic [1:0] rf, input logic gnd,
                          input logic [4:0] ch, input logic msk,
                          input logic win);
        int   n;
        logic agT, agC, pT, pC;
        agT = gnd && (ch != CH_TEMP);
        agC = gnd && (rf != REF_FAST);
        pT = 1'b0;
        pC = 1'b0;
        wr(OFF_REF, {29'h0, gnd, rf});
        wr(OFF_CHAN, {27'h0, ch});
        wr(OFF_CTRL1, {25'h0, rpt, tg, 1'b0});
        wr(OFF_MASK, {31'h0, msk});
        nRes = 0;
        sumExp = 16'h0;
        cvCnt = 0;
        case (tg)
            TRIG_SW: wr(OFF_CTRL0, 32'h10);
            TRIG_PIN: trigPin <= 1'b1;
            TRIG_TIMER: trigTimer <= 1'b1;
            default: trigLogic <= 1'b1;
        endcase
        n = 0;
        while (nRes < (1 << rpt) && n < 2000) begin
            @(posedge clk);
            n++;
            if (n == 3) {trigPin, trigTimer, trigLogic} <= 3'b000;
            // First cycle of a phase skipped: routing may lag one edge
            if (trackPhase === 1'b1 && pT) chkb(useAgnd, agT);
            if (convPhase === 1'b1 && pC) chkb(useAgnd, agC);
            if ((trackPhase === 1'b1 && pT) || (convPhase === 1'b1 && pC))
                chkb(fastRefEnable, rf == REF_FAST);
            pT = (trackPhase === 1'b1);
            pC = (convPhase === 1'b1);
        end
        if (n >= 2000) errors++;
        repeat (4) @(posedge clk);
        chkb(irq, msk);
        rd(OFF_DATA, {16'h0, sumExp});
        rd(OFF_STATUS, {30'h0, win, 1'b1});
        chkb(fastRefEnable, 1'b0);
        wr(OFF_STATUS, 32'h3);
        chkb(irq, 1'b0);
        rd(OFF_STATUS, 32'h0);
    endtask

    task automatic stop_test();
        if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, far beyond the expected several hundred cycles
    initial begin
        #300000;
        errors++;
        stop_test();
    end

    initial begin
        {psel, penable, pwrite, trigPin, trigTimer, trigLogic} = 6'h00;
        resultValid = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        resultIn = 12'h000;
        errors = 0;
        checks_done = 0;
        nRes = 0;
        cvCnt = 0;
        sumExp = 16'h0;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_chan();
        t_cfg();
        t_conv(TRIG_SW, 3'd0, REF_PIN, 1'b1, 5'h05, 1'b1, 1'b0);
        t_conv(TRIG_PIN, 3'd2, REF_FAST, 1'b1, 5'h03, 1'b1, 1'b0);
        t_conv(TRIG_TIMER, 3'd1, REF_SUPPLY, 1'b1, CH_TEMP, 1'b1, 1'b0);
        wr(OFF_WINHI, 32'h0000ffff);
        t_conv(TRIG_LOGIC, 3'd0, REF_REG, 1'b0, CH_LAST_EXT, 1'b0, 1'b1);
        stop_test();
    end
endmodule // tb_top
